/* File: src/hbs_bridge.v */
// host bridge configuration: straps, clock gate, memory rows, pci arbiter
// assumes pclk at 200 MHz, APB master on the same clock, pins unsynchronised
`include "hbs_regs.vh"
`default_nettype none
module hbs_bridge #(
  parameter NM = `HBS_NUM_MASTERS,
  parameter NR = `HBS_NUM_ROWS
) (
  input  wire                   pclk,
  input  wire                   presetn,
  input  wire                   psel,
  input  wire                   penable,
  input  wire                   pwrite,
  input  wire [`HBS_ADDR_W-1:0] paddr,
  input  wire [31:0]            pwdata,
  output reg  [31:0]            prdata,
  output reg                    pready,
  output reg                    pslverr,
  input  wire [5:0]             strap_pins,
  input  wire                   sys_idle,
  output reg                    int_clk_en,
  output reg  [3:0]             queue_depth,
  output reg                    quick_start_mode,
  output reg                    graphics_port_en,
  output reg                    mobile_buffer_mode,
  output reg                    host_66mhz,
  input  wire [NM-1:0]          pci_req_n,
  output reg  [NM-1:0]          pci_gnt_n,
  input  wire                   clkrun_n_in,
  output reg                    clkrun_n_out,
  output reg                    clkrun_n_oe_n,
  output reg                    pci_clk_run,
  output reg  [31:11]           idsel_ad,
  output reg                    cfg_active,
  output reg  [NR-1:0]          mem_cke,
  output reg                    mem_sdram_mode,
  output reg  [7:0]             edo_access_cyc
);
  reg  [1:0]    rel_sync_q;
  reg           strap_done_q;
  reg  [5:0]    strap_s1_q;
  reg  [5:0]    strap_s2_q;
  reg  [5:0]    strap_q;
  reg           pm_gclk_q;
  reg  [31:0]   cfg_q;
  reg  [NR-1:0] rows_q;
  reg           sdram_q;
  reg  [NM-1:0] req_s1_q;
  reg  [NM-1:0] req_s2_q;
  reg  [2:0]    last_q;
  reg  [NM-1:0] gnt_d;
  reg  [2:0]    last_d;
  reg  [1:0]    ckr_s_q;
  reg  [4:0]    idle_cnt_q;
  reg  [31:0]   rd_d;
  reg           err_d;
  reg  [4:0]    cfg_dev;
  wire          setup;
  wire          wr;
  wire [NM-1:0] reqs;
  integer       k;
  integer       idx;
  reg           found;

  // wide constants are cut to their targets on purpose
  localparam [31:0] LAST_RST = NM - 1;
  localparam [31:0] EDO_CYC  = `HBS_EDO_CYC;
  localparam [31:0] IDLE_CYC = `HBS_IDLE_CYC;

  // a configuration cycle starts only with both enable and go set
  function cfg_launch;
    input [31:0] cfg;
    begin
      cfg_launch = cfg[`HBS_CFG_EN] & cfg[`HBS_CFG_GO];
    end
  endfunction

  // devices 0 and 1 are internal, so they never drive an external select
  function [20:0] dev_select;
    input [4:0] dev;
    begin
      if (dev >= 5'h02)
        dev_select = 21'h1 << dev;
      else
        dev_select = 21'h0;
    end
  endfunction

  assign setup = psel & ~penable;
  assign wr = psel & penable & pwrite & pready;
  assign reqs = ~req_s2_q;

  // strap pins are sampled through two stages, then frozen once
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      strap_s1_q   <= 6'h00;
      strap_s2_q   <= 6'h00;
      strap_q      <= `HBS_STRAP_DEFAULT;
      rel_sync_q   <= 2'b00;
      strap_done_q <= 1'b0;
    end
    else
    begin
      strap_s1_q <= strap_pins;
      strap_s2_q <= strap_s1_q;
      rel_sync_q <= {rel_sync_q[0], 1'b1};
      // capture waits for the synced release so the pins have settled
      if (rel_sync_q[1] && !strap_done_q)
      begin
        strap_q      <= strap_s2_q;
        strap_done_q <= 1'b1;
      end
    end
  end

  // decoded modes from the frozen straps, sdram mode from the memory register; straps read high = on
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      host_66mhz         <= 1'b1;
      queue_depth        <= `HBS_QDEPTH_MAX;
      quick_start_mode   <= 1'b1;
      graphics_port_en   <= 1'b0;
      mobile_buffer_mode <= 1'b1;
      mem_sdram_mode     <= 1'b0;
      edo_access_cyc     <= 8'h00;
    end
    else
    begin
      // other frequency encodings are not offered on this module
      host_66mhz       <= 1'b1;
      queue_depth      <= strap_q[`HBS_ST_QDEPTH] ? `HBS_QDEPTH_MAX
                                                  : 4'h1;
      quick_start_mode <= strap_q[`HBS_ST_QSTART];
      // compatible mode has no graphics port whatever the strap says
      graphics_port_en <= 1'b0;
      mobile_buffer_mode <= strap_q[`HBS_ST_BUFM];
      mem_sdram_mode <= sdram_q;
      edo_access_cyc <= EDO_CYC[7:0];
    end
  end

  // idle clock gating: a short idle filter avoids gating on brief gaps
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      idle_cnt_q <= 5'h00;
      int_clk_en <= 1'b1;
    end
    else
    begin
      if (!sys_idle || !pm_gclk_q)
        idle_cnt_q <= 5'h00;
      else if (idle_cnt_q != IDLE_CYC[4:0])
        idle_cnt_q <= idle_cnt_q + 5'h01;
      int_clk_en <= ~(pm_gclk_q && sys_idle &&
                      idle_cnt_q == IDLE_CYC[4:0]);
    end
  end

  // one clock enable per populated bank, sharing one control set
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mem_cke <= {NR{1'b0}};
    else
      mem_cke <= rows_q & {NR{int_clk_en}};
  end

  // clock-run: we hold the line low while any master requests the bus
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ckr_s_q       <= 2'b11;
      clkrun_n_out  <= 1'b0;
      clkrun_n_oe_n <= 1'b1;
      pci_clk_run   <= 1'b1;
    end
    else
    begin
      ckr_s_q       <= {ckr_s_q[0], clkrun_n_in};
      // the shared line is only ever pulled low, never driven to a high level
      clkrun_n_out  <= 1'b0;
      clkrun_n_oe_n <= ~(|reqs);
      pci_clk_run   <= ~ckr_s_q[1] | (|reqs) | cfg_active;
    end
  end

  // rotating priority arbiter, search starts after the last grant
  always @*
  begin
    gnt_d  = pci_gnt_n;
    last_d = last_q;
    found  = 1'b0;
    idx    = 0;
    if (~&pci_gnt_n)
    begin
      // a grant is held until its own synced request goes away
      if (!(|(reqs & ~pci_gnt_n)))
        gnt_d = {NM{1'b1}};
    end
    else
    begin
      for (k = 1; k <= NM; k = k + 1)
      begin
        idx = (last_q + k) % NM;
        if (!found && reqs[idx])
        begin
          found  = 1'b1;
          gnt_d  = ~({{(NM-1){1'b0}}, 1'b1} << idx);
          last_d = idx[2:0];
        end
      end
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      req_s1_q  <= {NM{1'b1}};
      req_s2_q  <= {NM{1'b1}};
      pci_gnt_n <= {NM{1'b1}};
      last_q    <= LAST_RST[2:0];
    end
    else
    begin
      req_s1_q  <= pci_req_n;
      req_s2_q  <= req_s1_q;
      pci_gnt_n <= gnt_d;
      last_q    <= last_d;
    end
  end

  // configuration select: device number 2.. maps to ad line 11+dev
  always @*
  begin
    cfg_dev = cfg_q[`HBS_CFG_DEV_HI:`HBS_CFG_DEV_LO];
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      idsel_ad   <= 21'h0;
      cfg_active <= 1'b0;
    end
    else
    begin
      cfg_active <= cfg_launch(cfg_q);
      // device 0 is the bridge itself, device 1 is reserved internally
      if (cfg_launch(cfg_q))
        idsel_ad <= dev_select(cfg_dev);
      else
        idsel_ad <= 21'h0;
    end
  end

  // register file
  always @*
  begin
    err_d = 1'b0;
    case (paddr)
      `HBS_OFF_STRAP: rd_d = {26'h0, strap_q};
      `HBS_OFF_PM:    rd_d = {30'h0, ~int_clk_en, pm_gclk_q};
      `HBS_OFF_CFG:   rd_d = cfg_q;
      `HBS_OFF_ARB:   rd_d = {19'h0, last_q, 5'h0, ~pci_gnt_n};
      `HBS_OFF_MEM:   rd_d = {16'h0, 2'b00, rows_q, 7'h0, sdram_q};
      `HBS_OFF_ID:    rd_d = `HBS_ID_VALUE; // value arbitrary
      default:
      begin
        rd_d  = 32'h0;
        err_d = 1'b1;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      prdata    <= 32'h0;
      pm_gclk_q <= 1'b0;
      cfg_q     <= 32'h0;
      rows_q    <= {NR{1'b0}};
      sdram_q   <= 1'b0;
    end
    else
    begin
      pready  <= setup;
      pslverr <= setup & err_d;
      prdata  <= (setup && !pwrite) ? rd_d : 32'h0;
      if (cfg_q[`HBS_CFG_GO])
        cfg_q[`HBS_CFG_GO] <= 1'b0;
      if (wr)
      begin
        case (paddr)
          `HBS_OFF_PM:  pm_gclk_q <= pwdata[`HBS_PM_GCLK];
          `HBS_OFF_CFG: cfg_q <= pwdata;
          `HBS_OFF_MEM:
          begin
            // a single technology bit covers every row
            sdram_q <= pwdata[`HBS_MEM_SDRAM];
            rows_q  <= pwdata[`HBS_MEM_ROWS_LO +: NR];
          end
          // strap, arbiter and id words are read-only; writes are dropped
          default:
          begin
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

/* File: src/hbs_regs.vh */
// register map, strap positions and reset values for the host bridge block
// assumes APB byte addressing with one 32-bit word per register
`ifndef HBS_REGS_VH
`define HBS_REGS_VH
`define HBS_ADDR_W        8
`define HBS_OFF_STRAP     8'h00
`define HBS_OFF_PM        8'h04
`define HBS_OFF_CFG       8'h08
`define HBS_OFF_ARB       8'h0c
`define HBS_OFF_MEM       8'h10
`define HBS_OFF_ID        8'h14
`define HBS_ID_VALUE      32'h0000_5a01 // value arbitrary
// strap word bit positions
`define HBS_ST_FREQ       0
`define HBS_ST_QDEPTH     1
`define HBS_ST_QSTART     2
`define HBS_ST_GDIS       3
`define HBS_ST_MCFG       4
`define HBS_ST_BUFM       5
// default strap pattern when nothing is applied externally (pins pulled)
`define HBS_STRAP_DEFAULT 6'h3f
// power management register bits
`define HBS_PM_GCLK       0
// configuration access register fields
`define HBS_CFG_DEV_LO    11
`define HBS_CFG_DEV_HI    15
`define HBS_CFG_GO        31
`define HBS_CFG_EN        24
// memory register fields
`define HBS_MEM_SDRAM     0
`define HBS_MEM_ROWS_LO   8
`define HBS_NUM_ROWS      6
`define HBS_NUM_MASTERS   5
`define HBS_HOST_MHZ      66
`define HBS_QDEPTH_MAX    4'h8
`define HBS_EDO_NS        60
`define HBS_CLK_NS        5
`define HBS_EDO_CYC       ((`HBS_EDO_NS + `HBS_CLK_NS - 1) / `HBS_CLK_NS)
`define HBS_IDLE_CYC      16
`endif

/* File: test/hbs_props_properties.sv */
// assertions on the host bridge ports
// assumes it is bound into every bridge instance
`default_nettype none
module hbs_props #(
  parameter int NM = 5,
  parameter int NR = 6
) (
  input wire logic          pclk,
  input wire logic          presetn,
  input wire logic          sys_idle,
  input wire logic          int_clk_en,
  input wire logic [3:0]    queue_depth,
  input wire logic          quick_start_mode,
  input wire logic          graphics_port_en,
  input wire logic          mobile_buffer_mode,
  input wire logic          host_66mhz,
  input wire logic [NM-1:0] pci_req_n,
  input wire logic [NM-1:0] pci_gnt_n,
  input wire logic          clkrun_n_out,
  input wire logic          clkrun_n_oe_n,
  input wire logic [31:11]  idsel_ad,
  input wire logic          cfg_active,
  input wire logic [NR-1:0] mem_cke
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // straps settle a few edges after release, so hold is judged later
  always @(posedge pclk or negedge presetn)
    if (!presetn)
      cnt_q <= 4'h0;
    else if (cnt_q != 4'h8)
      cnt_q <= cnt_q + 4'h1;
  chk_one_grant: assert property ($onehot0(~pci_gnt_n))
    else $error("more than one grant");
  chk_grant_req: assert property (&pci_req_n [*6] |-> &pci_gnt_n)
    else $error("grant without request");
  chk_clkrun_held:
    assert property ((~&pci_req_n) [*5] |-> !(clkrun_n_oe_n | clkrun_n_out))
    else $error("clock-run line not driven");
  chk_gfx_off: assert property (!graphics_port_en)
    else $error("graphics port enabled");
  chk_bus_rate: assert property (host_66mhz)
    else $error("host rate not selected");
  chk_cke_gated: assert property (!int_clk_en [*2] |-> mem_cke == '0)
    else $error("clock enable while gated");
  chk_clk_wake: assert property (!sys_idle [*3] |-> int_clk_en)
    else $error("clock gated while busy");
  chk_idsel_low: assert property (!idsel_ad[11] && !idsel_ad[12])
    else $error("reserved select asserted");
  chk_idsel_cfg:
    assert property (idsel_ad != '0 |-> cfg_active && $onehot(idsel_ad))
    else $error("select outside a config cycle");
  chk_strap_held:
    assert property (cnt_q == 4'h8 |-> $stable({queue_depth,
      quick_start_mode, mobile_buffer_mode}))
    else $error("strap outputs changed");
endmodule
bind hbs_bridge hbs_props #(.NM(NM), .NR(NR)) u_props (
  .pclk               (pclk),
  .presetn            (presetn),
  .sys_idle           (sys_idle),
  .int_clk_en         (int_clk_en),
  .queue_depth        (queue_depth),
  .quick_start_mode   (quick_start_mode),
  .graphics_port_en   (graphics_port_en),
  .mobile_buffer_mode (mobile_buffer_mode),
  .host_66mhz         (host_66mhz),
  .pci_req_n          (pci_req_n),
  .pci_gnt_n          (pci_gnt_n),
  .clkrun_n_out       (clkrun_n_out),
  .clkrun_n_oe_n      (clkrun_n_oe_n),
  .idsel_ad           (idsel_ad),
  .cfg_active         (cfg_active),
  .mem_cke            (mem_cke)
);
`default_nettype wire

/* File: test/hbs_pci_masters.sv */
// model of the pci bus masters on the system board
// assumes active-low request/grant pairs and a pulled-up clock-run line
`default_nettype none
module hbs_pci_masters #(
  parameter int NM = 5
) (
  input  wire logic          pclk,
  input  wire logic [NM-1:0] want,
  input  wire logic [NM-1:0] gnt_n,
  output var  logic [NM-1:0] req_n,
  output wire logic          clkrun_n,
  output var  logic [NM-1:0] done
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic [NM-1:0] got;
  initial
  begin
    req_n = '1;
    done = '0;
  end
  // one tenure per want: the bus is used only once the grant is seen
  assign got = want & (done | (~gnt_n & ~req_n));
  always @(posedge pclk)
  begin
    done <= got;
    req_n <= ~(want & ~got);
  end
  assign clkrun_n = &req_n;
endmodule
`default_nettype wire

/* File: test/testbench.sv */
// self-checking bench for the host bridge
// assumes the bridge, its header and the master model are compiled
`include "hbs_regs.vh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic         pclk, presetn, psel, penable, pwrite, sys_idle, perr;
  logic         pready, pslverr, int_clk_en, quick_start_mode, host_66mhz;
  logic         graphics_port_en, mobile_buffer_mode, pci_clk_run;
  logic         clkrun_n_in, clkrun_n_out, clkrun_n_oe_n, cfg_active;
  logic         mem_sdram_mode, act;
  logic [7:0]   paddr, edo_access_cyc;
  logic [31:0]  pwdata, prdata, q;
  logic [3:0]   queue_depth;
  logic [5:0]   strap_pins, mem_cke;
  logic [4:0]   pci_req_n, pci_gnt_n, want, done, last_g;
  logic [31:11] idsel_ad, seen;
  wire logic    dev_clkrun_n;
  int           miscompares = 0, n_compared = 0, cycles = 0, n;
  int           order[$];
  int           devs[5] = '{0, 1, 2, 7, 20};
  hbs_bridge u_dut (
    .pclk               (pclk),
    .presetn            (presetn),
    .psel               (psel),
    .penable            (penable),
    .pwrite             (pwrite),
    .paddr              (paddr),
    .pwdata             (pwdata),
    .prdata             (prdata),
    .pready             (pready),
    .pslverr            (pslverr),
    .strap_pins         (strap_pins),
    .sys_idle           (sys_idle),
    .int_clk_en         (int_clk_en),
    .queue_depth        (queue_depth),
    .quick_start_mode   (quick_start_mode),
    .graphics_port_en   (graphics_port_en),
    .mobile_buffer_mode (mobile_buffer_mode),
    .host_66mhz         (host_66mhz),
    .pci_req_n          (pci_req_n),
    .pci_gnt_n          (pci_gnt_n),
    .clkrun_n_in        (clkrun_n_in),
    .clkrun_n_out       (clkrun_n_out),
    .clkrun_n_oe_n      (clkrun_n_oe_n),
    .pci_clk_run        (pci_clk_run),
    .idsel_ad           (idsel_ad),
    .cfg_active         (cfg_active),
    .mem_cke            (mem_cke),
    .mem_sdram_mode     (mem_sdram_mode),
    .edo_access_cyc     (edo_access_cyc)
  );
  hbs_pci_masters u_pci (.pclk(pclk), .want(want), .gnt_n(pci_gnt_n),
    .req_n(pci_req_n), .clkrun_n(dev_clkrun_n), .done(done));
  assign clkrun_n_in = dev_clkrun_n & (clkrun_n_oe_n | clkrun_n_out);
  initial
  begin
    pclk = 1'h0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge pclk)
  begin
    if (pci_gnt_n != 5'h1f && ~pci_gnt_n != last_g)
      order.push_back($clog2(~pci_gnt_n));
    last_g <= ~pci_gnt_n;
  end
  // the ceiling is far above the few hundred cycles the tests need
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      miscompares++;
      close_out();
    end
  end
  task automatic chk(input string nm, input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    // no cycle count is assumed; the bench timeout ends a lost answer
    do
      @(posedge pclk);
    while (pready !== 1'h1);
    q = prdata;
    perr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rst(input logic [5:0] s);
    strap_pins <= s;
    presetn <= 1'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    repeat (8) @(posedge pclk);
  endtask
  initial
  begin
    {psel, penable, pwrite, sys_idle, paddr, pwdata, want, last_g} = '0;
    rst(6'h3f);
    chk("qdepth", queue_depth, 4'h8);
    chk("qstart", quick_start_mode, 1'h1);
    chk("bufmode", mobile_buffer_mode, 1'h1);
    apb(1'h0, `HBS_OFF_ID, 32'h0);
    chk("id", q, `HBS_ID_VALUE);
    apb(1'h0, 8'h40, 32'h0);
    chk("unmapped err", perr, 1'h1);
    chk("unmapped", q, 32'h0);
    // mid-run reset with overriding straps, then pins move
    rst(6'h19);
    strap_pins <= 6'h3f;
    apb(1'h1, `HBS_OFF_STRAP, 32'h0);
    apb(1'h0, `HBS_OFF_STRAP, 32'h0);
    chk("strap", q, 32'h19);
    chk("qdepth", queue_depth, 4'h1);
    chk("modes", {quick_start_mode, mobile_buffer_mode}, 2'h0);
    apb(1'h1, `HBS_OFF_MEM, 32'h3f01);
    repeat (2) @(posedge pclk);
    chk("sdram", {mem_sdram_mode, mem_cke}, 7'h7f);
    apb(1'h1, `HBS_OFF_MEM, 32'h0500);
    repeat (2) @(posedge pclk);
    chk("cke", mem_cke, 6'h05);
    chk("edo", {mem_sdram_mode, edo_access_cyc}, 9'h00c);
    apb(1'h1, `HBS_OFF_PM, 32'h1);
    sys_idle <= 1'h1;
    repeat (20) @(posedge pclk);
    chk("gate", {int_clk_en, mem_cke}, 7'h00);
    apb(1'h0, `HBS_OFF_PM, 32'h0);
    chk("pm", q, 32'h3);
    sys_idle <= 1'h0;
    repeat (4) @(posedge pclk);
    chk("wake", {int_clk_en, mem_cke}, 7'h45);
    foreach (devs[i])
    begin
      apb(1'h1, `HBS_OFF_CFG, 32'h8100_0000 | (devs[i] << 11));
      seen = '0;
      act = 1'h0;
      repeat (4)
      begin
        @(posedge pclk);
        seen |= idsel_ad;
        act |= cfg_active;
      end
      chk("idsel", seen, devs[i] < 2 ? 0 : 1 << devs[i]);
      chk("cfg active", act, 1'h1);
    end
    order.delete();
    want <= 5'h1f;
    repeat (8) @(posedge pclk);
    chk("clkrun", {clkrun_n_oe_n, clkrun_n_in, pci_clk_run}, 3'h1);
    for (n = 0; n < 300 && done !== 5'h1f; n++)
      @(posedge pclk);
    chk("served", {done, 3'(order.size())}, 8'hfd);
    for (n = 1; n < order.size(); n++)
      chk("order", order[n], (order[n-1] + 1) % 5);
    want <= 5'h0;
    repeat (10) @(posedge pclk);
    chk("clk idle", {clkrun_n_oe_n, clkrun_n_in, pci_clk_run}, 3'h6);
    close_out();
  end
endmodule
`default_nettype wire
